/* hdl/spmc_ctrl.sv */
// spmc_ctrl: motion-controller end that drives the pulse link, with
// an axi4-lite slave for software.
// assumes ref_clk at 200 MHz and one outstanding access per channel
// pair; timing from the driver is an asynchronous level.
`timescale 1ns/1ps
module spmc_ctrl #(
	parameter int unsigned SETTLE_CYCLES = spmc_pkg::SPMC_SETTLE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link to the driver
	spmc_link_if.ctl link
);
	import spmc_pkg::*;

	logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
	logic arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q, wmask, rd_d;
	logic [7:0] awaddr_q;
	logic [3:0] wstrb_q;
	logic wr_do, aw_hs, w_hs, ar_hs, rd_ok;
	logic [2:0] ctrl_q;
	spmc_cnt_t half_q, remain_q, hcnt_q;
	logic mv_go, fwd_q, last_fwd_q, res_q;
	logic pa_q, pb_q, tim_meta_q, tim_q, awoff_q;
	logic [31:0] wait_q, settle_q;
	spmc_seq_t st_q;

	// write channel capture, either order, response after both
	assign aw_hs = s_axi_awvalid & awready_q;
	assign w_hs = s_axi_wvalid & wready_q;
	assign wr_do = aw_full_q & w_full_q & ~bvalid_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= SPMC_RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_full_q <= (aw_full_q | aw_hs) & ~wr_do;
			w_full_q <= (w_full_q | w_hs) & ~wr_do;
			awready_q <= ~(aw_full_q | aw_hs) | wr_do;
			wready_q <= ~(w_full_q | w_hs) | wr_do;
			if (wr_do) begin
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr_q[7:2] <= SPMC_REG_HALF[7:2] &&
					awaddr_q != SPMC_REG_STATUS) ?
					SPMC_RESP_OKAY : SPMC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// byte enables widened to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_q[i]}};
		end
	end

	// control and pulse-width registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctrl_q <= SPMC_CTRL_RST;
			half_q <= SPMC_HALF_RST;
		end else if (wr_do && awaddr_q == SPMC_REG_CTRL) begin
			ctrl_q <= (ctrl_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
		end else if (wr_do && awaddr_q == SPMC_REG_HALF) begin
			half_q <= (half_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
		end
	end

	// a move is taken only idle, with windings on and a nonzero count
	assign mv_go = wr_do && awaddr_q == SPMC_REG_MOVE && st_q == SPMC_ST_IDLE
		&& !ctrl_q[SPMC_CTRL_AWOFF] && wdata_q[15:0] != '0;

	// read channel
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			SPMC_REG_CTRL: rd_d = {29'h0, ctrl_q};
			SPMC_REG_MOVE: rd_d = {15'h0, fwd_q, remain_q};
			SPMC_REG_STATUS: rd_d = {remain_q, 13'h0,
				ctrl_q[SPMC_CTRL_RES_SEL] != res_q, tim_q,
				st_q != SPMC_ST_IDLE};
			SPMC_REG_HALF: rd_d = {16'h0, half_q};
			default: begin
				rd_d = '0;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign ar_hs = s_axi_arvalid & arready_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= SPMC_RESP_OKAY;
		end else if (ar_hs) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? SPMC_RESP_OKAY : SPMC_RESP_SLVERR;
		end else if (rvalid_q) begin
			rvalid_q <= ~s_axi_rready;
			arready_q <= s_axi_rready;
		end else begin
			arready_q <= 1'b1;
		end
	end

	// timing level from the driver, two-flop synchronised
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tim_meta_q <= 1'b0;
			tim_q <= 1'b0;
		end else begin
			tim_meta_q <= link.timing;
			tim_q <= tim_meta_q;
		end
	end

	// windings-off and settle time after its release
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			awoff_q <= 1'b0;
			settle_q <= '0;
		end else begin
			awoff_q <= ctrl_q[SPMC_CTRL_AWOFF];
			if (awoff_q && !ctrl_q[SPMC_CTRL_AWOFF]) begin
				settle_q <= SETTLE_CYCLES;
			end else if (settle_q != '0) begin
				settle_q <= settle_q - 32'd1;
			end
		end
	end

	// resolution select follows software only stopped with timing on
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			res_q <= 1'b0;
		end else if (st_q == SPMC_ST_IDLE && tim_q) begin
			res_q <= ctrl_q[SPMC_CTRL_RES_SEL];
		end
	end

	// pulse sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q <= SPMC_ST_IDLE;
			wait_q <= '0;
			hcnt_q <= '0;
			remain_q <= '0;
			fwd_q <= 1'b0;
			last_fwd_q <= 1'b0;
		end else begin
			case (st_q)
				SPMC_ST_IDLE: begin
					if (mv_go) begin
						fwd_q <= wdata_q[SPMC_MOVE_FWD];
						remain_q <= wdata_q[15:0];
						// a reversal first waits out the direction gap; so does
						// every one-pulse move, as a mode switch moves the pin
						wait_q <= (wdata_q[SPMC_MOVE_FWD] != last_fwd_q ||
							ctrl_q[SPMC_CTRL_ONE_PULSE]) ?
							SPMC_DIR_GAP_CYC : '0;
						st_q <= SPMC_ST_WAIT;
					end
				end
				SPMC_ST_WAIT: begin
					last_fwd_q <= fwd_q;
					if (wait_q != '0) begin
						wait_q <= wait_q - 32'd1;
					end else if (settle_q == '0) begin
						hcnt_q <= half_q;
						st_q <= SPMC_ST_HIGH;
					end
				end
				SPMC_ST_HIGH: begin
					if (hcnt_q > 16'd1) begin
						hcnt_q <= hcnt_q - 16'd1;
					end else begin
						hcnt_q <= half_q;
						st_q <= SPMC_ST_LOW;
					end
				end
				SPMC_ST_LOW: begin
					if (hcnt_q > 16'd1) begin
						hcnt_q <= hcnt_q - 16'd1;
					end else if (remain_q == 16'd1) begin
						remain_q <= '0;
						st_q <= SPMC_ST_IDLE;
					end else begin
						remain_q <= remain_q - 16'd1;
						hcnt_q <= half_q;
						st_q <= SPMC_ST_HIGH;
					end
				end
				default: st_q <= SPMC_ST_IDLE;
			endcase
		end
	end

	// pin drive: in two-pulse mode one pin conducts at a time and idle pins are off; in one-pulse mode pulse_b holds the direction level
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pa_q <= 1'b0;
			pb_q <= 1'b0;
		end else if (ctrl_q[SPMC_CTRL_ONE_PULSE]) begin
			pa_q <= (st_q == SPMC_ST_HIGH);
			pb_q <= (st_q == SPMC_ST_IDLE) ? last_fwd_q : fwd_q;
		end else begin
			pa_q <= (st_q == SPMC_ST_HIGH) && fwd_q;
			pb_q <= (st_q == SPMC_ST_HIGH) && !fwd_q;
		end
	end

	// outputs straight from flops
	assign link.pulse_a = pa_q;
	assign link.pulse_b = pb_q;
	assign link.awoff = awoff_q;
	assign link.res_sel = res_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule

/* hdl/spmc_pkg.sv */
// spmc_pkg: shared constants and types of the microstep pulse link.
// assumes a 200 MHz ref_clk on both ends; all link levels are
// 1 = photocoupler conducting, 0 = not conducting.
package spmc_pkg;

	// basic types
	typedef logic [3:0] spmc_code_t;
	typedef logic [17:0] spmc_units_t;
	typedef logic [20:0] spmc_phase_t;
	typedef logic [15:0] spmc_cnt_t;

	// clock rate and timing figures
	localparam int unsigned SPMC_CLK_MHZ = 200;
	localparam int unsigned SPMC_DIR_GAP_US = 10;
	localparam int unsigned SPMC_DIR_GAP_CYC = SPMC_DIR_GAP_US * SPMC_CLK_MHZ;
	localparam int unsigned SPMC_SETTLE_MS = 1;
	localparam int unsigned SPMC_SETTLE_CYC =
		SPMC_SETTLE_MS * 1000 * SPMC_CLK_MHZ;
	localparam int unsigned SPMC_STANDSTILL_MS = 100;
	localparam int unsigned SPMC_STANDSTILL_CYC =
		SPMC_STANDSTILL_MS * 1000 * SPMC_CLK_MHZ;

	// travel per microstep in units of 1/64000 full step
	localparam spmc_units_t SPMC_TBL_FIRST [16] = '{
		18'h0_FA00, 18'h0_7D00, 18'h0_6400, 18'h0_3E80,
		18'h0_3200, 18'h0_1F40, 18'h0_1900, 18'h0_0C80,
		18'h0_0A00, 18'h0_0640, 18'h0_0500, 18'h0_0320,
		18'h0_0280, 18'h0_0200, 18'h0_0140, 18'h0_0100};
	localparam spmc_units_t SPMC_TBL_SECOND [16] = '{
		18'h2_7100, 18'h1_3880, 18'h0_9C40, 18'h0_7D00,
		18'h0_4E20, 18'h0_3E80, 18'h0_2710, 18'h0_1900,
		18'h0_1388, 18'h0_0C80, 18'h0_09C4, 18'h0_0640,
		18'h0_0500, 18'h0_04E2, 18'h0_0280, 18'h0_0271};

	// one timing cycle: 10 full steps, 20 on a high-resolution motor
	localparam spmc_phase_t SPMC_PERIOD_STD = 21'h0_9_C400;
	localparam spmc_phase_t SPMC_PERIOD_HI = 21'h1_3_8800;

	// synchroniser slots on the device
	localparam int unsigned SPMC_IN_A = 0;
	localparam int unsigned SPMC_IN_B = 1;
	localparam int unsigned SPMC_IN_AWOFF = 2;
	localparam int unsigned SPMC_IN_RES = 3;
	localparam int unsigned SPMC_NIN = 4;

	// controller register offsets (byte addresses)
	localparam logic [7:0] SPMC_REG_CTRL = 8'h00;
	localparam logic [7:0] SPMC_REG_MOVE = 8'h04;
	localparam logic [7:0] SPMC_REG_STATUS = 8'h08;
	localparam logic [7:0] SPMC_REG_HALF = 8'h0C;

	// field positions
	localparam int unsigned SPMC_CTRL_ONE_PULSE = 0;
	localparam int unsigned SPMC_CTRL_AWOFF = 1;
	localparam int unsigned SPMC_CTRL_RES_SEL = 2;
	localparam int unsigned SPMC_MOVE_FWD = 16;
	localparam int unsigned SPMC_ST_BUSY = 0;
	localparam int unsigned SPMC_ST_TIMING = 1;
	localparam int unsigned SPMC_ST_RES_PEND = 2;
	localparam int unsigned SPMC_ST_REMAIN = 16;

	// reset values
	localparam logic [2:0] SPMC_CTRL_RST = 3'h0;
	localparam spmc_cnt_t SPMC_HALF_RST = 16'h0064;

	// axi responses
	localparam logic [1:0] SPMC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPMC_RESP_SLVERR = 2'h2;

	// controller sequencer states
	typedef enum logic [1:0] {
		SPMC_ST_IDLE = 2'b00,
		SPMC_ST_WAIT = 2'b01,
		SPMC_ST_HIGH = 2'b10,
		SPMC_ST_LOW = 2'b11
	} spmc_seq_t;

endpackage

/* hdl/spmc_link_if.sv */
// spmc_link_if: the isolated input/output wires between controller
// and driver. pulse_a carries the step pulse (one-pulse mode) or the
// forward pulse (two-pulse mode); pulse_b carries direction or the
// reverse pulse. 1 means the photocoupler conducts.
`timescale 1ns/1ps
interface spmc_link_if;
	logic pulse_a;
	logic pulse_b;
	logic awoff;
	logic res_sel;
	logic timing;

	modport dev (
		input pulse_a,
		input pulse_b,
		input awoff,
		input res_sel,
		output timing
	);

	modport ctl (
		output pulse_a,
		output pulse_b,
		output awoff,
		output res_sel,
		input timing
	);
endinterface

/* hdl/spmc_device.sv */
// spmc_device: driver-side input and sequencing logic of a
// microstepping actuator driver.
// assumes ref_clk at 200 MHz; link inputs are asynchronous levels and
// switch inputs are static straps.
`timescale 1ns/1ps
module spmc_device #(
	parameter int unsigned STANDSTILL_CYCLES = spmc_pkg::SPMC_STANDSTILL_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// link to the controller
	spmc_link_if.dev link,
	// setting switches
	input wire logic one_pulse_mode,
	input wire logic table_second_sel,
	input wire logic hi_res_motor,
	input wire spmc_pkg::spmc_code_t res_preset_a,
	input wire spmc_pkg::spmc_code_t res_preset_b,
	// power stage side
	output logic microstep,
	output logic step_fwd,
	output logic wind_on,
	output logic current_reduced,
	output spmc_pkg::spmc_units_t step_units,
	output spmc_pkg::spmc_phase_t phase
);
	import spmc_pkg::*;

	logic [SPMC_NIN-1:0] raw;
	logic [SPMC_NIN-1:0] meta_q;
	logic [SPMC_NIN-1:0] sync_q;
	logic [SPMC_NIN-1:0] prev_q;
	logic [SPMC_NIN-1:0] fall;
	logic step_req;
	logic step_dir;
	logic wind_q;
	logic microstep_q;
	logic step_fwd_q;
	logic reduced_q;
	logic timing_q;
	logic [31:0] idle_cnt_q;
	logic pulses_idle;
	spmc_code_t code;
	spmc_units_t units_q;
	spmc_units_t units_d;
	spmc_phase_t period;
	spmc_phase_t phase_q;
	spmc_phase_t phase_d;
	logic [21:0] fwd_sum;

	// gather the link levels for the synchronisers
	assign raw[SPMC_IN_A] = link.pulse_a;
	assign raw[SPMC_IN_B] = link.pulse_b;
	assign raw[SPMC_IN_AWOFF] = link.awoff;
	assign raw[SPMC_IN_RES] = link.res_sel;

	// two-flop synchroniser plus an edge history stage per input
	genvar gi;
	generate
		for (gi = 0; gi < SPMC_NIN; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= raw[gi];
					sync_q[gi] <= meta_q[gi];
					prev_q[gi] <= sync_q[gi];
				end
			end
			// conducting to non-conducting, seen on settled levels only
			assign fall[gi] = prev_q[gi] & ~sync_q[gi];
		end
	endgenerate

	// decode the pulse inputs into one step request per edge
	always_comb begin
		step_req = 1'b0;
		step_dir = 1'b0;
		if (one_pulse_mode) begin
			// direction conducting means forward
			step_req = fall[SPMC_IN_A];
			step_dir = sync_q[SPMC_IN_B];
		end else if (fall[SPMC_IN_A] != fall[SPMC_IN_B]) begin
			// a simultaneous fall on both pins is dropped as illegal
			step_req = 1'b1;
			step_dir = fall[SPMC_IN_A];
		end
	end

	// windings follow the windings-off level
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wind_q <= 1'b0;
		end else begin
			wind_q <= ~sync_q[SPMC_IN_AWOFF];
		end
	end

	// step strobe to the power stage; no motion without current
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			microstep_q <= 1'b0;
			step_fwd_q <= 1'b0;
		end else begin
			microstep_q <= step_req & wind_q;
			if (step_req) begin
				step_fwd_q <= step_dir;
			end
		end
	end

	// active dial and table; both dials index the same table
	assign code = sync_q[SPMC_IN_RES] ? res_preset_b : res_preset_a;
	always_comb begin
		if (table_second_sel) begin
			units_d = SPMC_TBL_SECOND[code];
		end else begin
			units_d = SPMC_TBL_FIRST[code];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			units_q <= SPMC_TBL_FIRST[0];
		end else begin
			units_q <= units_d;
		end
	end

	// a high-resolution motor needs twice the steps per timing cycle
	assign period = hi_res_motor ? SPMC_PERIOD_HI : SPMC_PERIOD_STD;
	assign fwd_sum = {1'b0, phase_q} + {4'h0, units_q};

	// phase accumulator wraps modulo one timing cycle
	always_comb begin
		phase_d = phase_q;
		if (step_req && wind_q) begin
			if (step_dir) begin
				if (fwd_sum >= {1'b0, period}) begin
					phase_d = 21'(fwd_sum - {1'b0, period});
				end else begin
					phase_d = fwd_sum[20:0];
				end
			end else if (phase_q < {3'h0, units_q}) begin
				phase_d = 21'(phase_q + period - {3'h0, units_q});
			end else begin
				phase_d = phase_q - {3'h0, units_q};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_d;
		end
	end

	// timing output conducts while the phase sits on the boundary
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			timing_q <= 1'b0;
		end else begin
			timing_q <= (phase_q == '0);
		end
	end

	// reduced standstill current after the pulse pins stay idle
	assign pulses_idle = one_pulse_mode ? ~sync_q[SPMC_IN_A] :
		~(sync_q[SPMC_IN_A] | sync_q[SPMC_IN_B]);
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			idle_cnt_q <= '0;
			reduced_q <= 1'b0;
		end else if (!pulses_idle) begin
			// a conducting pulse pin keeps full current
			idle_cnt_q <= '0;
			reduced_q <= 1'b0;
		end else if (idle_cnt_q >= STANDSTILL_CYCLES - 1) begin
			reduced_q <= wind_q;
		end else begin
			idle_cnt_q <= idle_cnt_q + 32'd1;
		end
	end

	// outputs straight from flops
	assign link.timing = timing_q;
	assign microstep = microstep_q;
	assign step_fwd = step_fwd_q;
	assign wind_on = wind_q;
	assign current_reduced = reduced_q;
	assign step_units = units_q;
	assign phase = phase_q;
endmodule

/* bench/spmc_link_monitor.sv */
// spmc_link_monitor: assertions on the controller-to-driver link.
// takes link wires and first driver outputs as plain inputs.
`timescale 1ns/1ps
module spmc_link_monitor #(
	parameter int unsigned SETTLE_CYCLES = 20,
	parameter int unsigned STANDSTILL_CYCLES = 50
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// link wires
	input wire logic pulse_a,
	input wire logic pulse_b,
	input wire logic awoff,
	input wire logic res_sel,
	input wire logic timing,
	// driver strap and outputs
	input wire logic one_pulse_mode,
	input wire logic microstep,
	input wire logic step_fwd,
	input wire logic wind_on,
	input wire logic current_reduced
);
	import spmc_pkg::*;
	logic [31:0] settle_q;
	logic [31:0] gap_q;
	logic [31:0] quiet_q;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// cycles since windings-off was last on
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			settle_q <= SETTLE_CYCLES;
		else if (awoff)
			settle_q <= '0;
		else if (settle_q < SETTLE_CYCLES)
			settle_q <= settle_q + 1;
	end
	// cycles since the direction level last moved
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			gap_q <= SPMC_DIR_GAP_CYC;
		else if ($changed(pulse_b))
			gap_q <= '0;
		else if (gap_q < SPMC_DIR_GAP_CYC)
			gap_q <= gap_q + 1;
	end
	// cycles with the pulse pins quiet; reset counts as quiet
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			quiet_q <= STANDSTILL_CYCLES;
		else if (pulse_a || (!one_pulse_mode && pulse_b))
			quiet_q <= '0;
		else if (quiet_q < STANDSTILL_CYCLES)
			quiet_q <= quiet_q + 1;
	end

	// falling pins while current is on, and the step they give
	sequence fwd_fall_s;
		!one_pulse_mode && !pulse_b && $fell(pulse_a) && wind_on;
	endsequence
	sequence rev_fall_s;
		!one_pulse_mode && !pulse_a && $fell(pulse_b) && wind_on;
	endsequence
	sequence dir_fall_s;
		one_pulse_mode && $fell(pulse_a) && wind_on;
	endsequence
	sequence step_s(logic d);
		##[2:5] (microstep && step_fwd == d);
	endsequence

	fwd_step_a: assert property (fwd_fall_s |-> step_s(1'b1))
		else $error("forward pulse gave no forward step");
	rev_step_a: assert property (rev_fall_s |-> step_s(1'b0))
		else $error("reverse pulse gave no backward step");
	dir_step_a: assert property (dir_fall_s |-> step_s(pulse_b))
		else $error("step pulse moved the wrong way");
	no_both_a: assert property (!one_pulse_mode |-> !(pulse_a && pulse_b))
		else $error("both pulse pins on together");
	wind_off_a: assert property (awoff [*6] |-> !wind_on && !microstep)
		else $error("current still on with windings off");
	wind_on_a: assert property (!awoff [*6] |-> wind_on)
		else $error("current not restored");
	settle_gap_a: assert property ($rose(pulse_a) |->
		!awoff && settle_q >= SETTLE_CYCLES - 1)
		else $error("pulse too soon after windings-off");
	dir_gap_a: assert property (one_pulse_mode && $rose(pulse_a) |->
		gap_q >= SPMC_DIR_GAP_CYC - 1)
		else $error("pulse too soon after direction change");
	res_switch_a: assert property ($changed(res_sel) |->
		timing && $past(timing, 2) && !pulse_a)
		else $error("resolution switched while moving");
	standstill_a: assert property ($rose(current_reduced) |->
		quiet_q >= STANDSTILL_CYCLES)
		else $error("current reduced too early");
endmodule

/* bench/step_pulse_microstep_control_test.sv */
// step_pulse_microstep_control_test: controller and driver joined on
// one link; a second driver is driven straight from the bench.
`timescale 1ns/1ps
module step_pulse_microstep_control_test;
	import spmc_pkg::*;
	localparam int unsigned SETTLE = 20;
	localparam int unsigned STILL = 50;
	// division x10 per dial code; second table 0,1 are travel x2.5, x1.25
	localparam int D10 [2][16] = '{
		'{10, 20, 25, 40, 50, 80, 100, 200, 250, 400, 500, 800,
			1000, 1250, 2000, 2500},
		'{4, 8, 16, 20, 32, 40, 64, 100, 128, 200, 256, 400,
			500, 512, 1000, 1024}};
	logic ref_clk, rst_b;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic one_pulse_mode, table_second_sel, hi_res_motor;
	spmc_code_t res_preset_a, res_preset_b;
	logic ms [2], sfwd [2], won [2], cred [2];
	spmc_units_t units [2];
	int fail_count, n_tests, n, ex;
	int cf [2], cr [2];
	spmc_link_if spmc_link_if_i ();
	spmc_link_if spmc_link_if_i2 ();

	spmc_ctrl #(.SETTLE_CYCLES(SETTLE)) spmc_ctrl_i (.ref_clk, .rst_b,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .link(spmc_link_if_i));
	spmc_device #(.STANDSTILL_CYCLES(STILL)) spmc_device_i (.ref_clk,
		.rst_b, .link(spmc_link_if_i), .one_pulse_mode, .table_second_sel,
		.hi_res_motor, .res_preset_a, .res_preset_b, .microstep(ms[0]),
		.step_fwd(sfwd[0]), .wind_on(won[0]), .current_reduced(cred[0]),
		.step_units(units[0]), .phase());
	spmc_device #(.STANDSTILL_CYCLES(STILL)) spmc_device_i2 (.ref_clk,
		.rst_b, .link(spmc_link_if_i2), .one_pulse_mode, .table_second_sel,
		.hi_res_motor, .res_preset_a, .res_preset_b, .microstep(ms[1]),
		.step_fwd(sfwd[1]), .wind_on(won[1]), .current_reduced(cred[1]),
		.step_units(units[1]), .phase());
	spmc_link_monitor #(.SETTLE_CYCLES(SETTLE), .STANDSTILL_CYCLES(STILL))
		spmc_link_monitor_i (.ref_clk, .rst_b,
		.pulse_a(spmc_link_if_i.pulse_a), .pulse_b(spmc_link_if_i.pulse_b),
		.awoff(spmc_link_if_i.awoff), .res_sel(spmc_link_if_i.res_sel),
		.timing(spmc_link_if_i.timing), .one_pulse_mode,
		.microstep(ms[0]), .step_fwd(sfwd[0]), .wind_on(won[0]),
		.current_reduced(cred[0]));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// count microsteps per direction on both drivers
	always @(posedge ref_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (ms[i] === 1'b1 && sfwd[i] === 1'b1)
				cf[i]++;
			else if (ms[i] === 1'b1)
				cr[i]++;
		end
	end

	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// axi write: aw and w offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			k++;
		end while (!s_axi_bvalid && k < 200);
		s_axi_bready <= 1'b0;
		if (k >= 200)
			hang();
		chk(s_axi_bresp, er);
	endtask
	// axi read into rd_d, response checked
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			k++;
		end while (!s_axi_rvalid && k < 200);
		rd_d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		if (k >= 200)
			hang();
		chk(s_axi_rresp, er);
	endtask
	// poll status until the controller stops stepping
	task automatic idle();
		int k;
		k = 0;
		do begin
			rd(SPMC_REG_STATUS, SPMC_RESP_OKAY);
			k++;
		end while (rd_d[SPMC_ST_BUSY] !== 1'b0 && k < 2000);
		if (k >= 2000)
			hang();
	endtask
	// one pulse on the bench-driven link; b is direction in one-pulse
	task automatic pulse2(input logic a, input logic b);
		@(posedge ref_clk);
		spmc_link_if_i2.pulse_a <= a;
		spmc_link_if_i2.pulse_b <= b;
		repeat (4) @(posedge ref_clk);
		spmc_link_if_i2.pulse_a <= 1'b0;
		spmc_link_if_i2.pulse_b <= one_pulse_mode ? b : 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask
	// compare step counts of one driver, then restart them
	task automatic steps(input int i, input int f, input int r);
		chk(cf[i], f);
		chk(cr[i], r);
		cf[i] = 0;
		cr[i] = 0;
	endtask

	initial begin
		// time-zero values and reset
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		{one_pulse_mode, table_second_sel, hi_res_motor} = '0;
		{res_preset_a, res_preset_b} = '0;
		{spmc_link_if_i2.pulse_a, spmc_link_if_i2.pulse_b} = '0;
		{spmc_link_if_i2.awoff, spmc_link_if_i2.res_sel} = '0;
		{fail_count, n_tests, cf[0], cf[1], cr[0], cr[1]} = '0;
		rst_b = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(units[0], 32'h0000_FA00);
		// rows: table, dial code, select line -> travel per microstep
		for (int t = 0; t < 2; t++)
			for (int c = 0; c < 16; c++)
				for (int s = 0; s < 2; s++) begin
					ex = 640000 / D10[t][c];
					@(posedge ref_clk);
					table_second_sel <= t[0];
					res_preset_a <= s[0] ? ~c[3:0] : c[3:0];
					res_preset_b <= s[0] ? c[3:0] : ~c[3:0];
					spmc_link_if_i2.res_sel <= s[0];
					// select crosses two flops, then the table flop
					repeat (4) @(posedge ref_clk);
					chk(units[1], ex);
				end
		@(posedge ref_clk);
		{table_second_sel, res_preset_b, spmc_link_if_i2.res_sel} <= '0;
		// ten forward pulses: timing only at the tenth
		for (int i = 1; i <= 10; i++) begin
			pulse2(1'b1, 1'b0);
			chk(spmc_link_if_i2.timing, i == 10);
		end
		steps(1, 10, 0);
		repeat (2000) @(posedge ref_clk);
		repeat (10) pulse2(1'b0, 1'b1);
		steps(1, 0, 10);
		chk(spmc_link_if_i2.timing, 1);
		pulse2(1'b1, 1'b1);
		steps(1, 0, 0);
		// windings off drops steps; release restores current
		spmc_link_if_i2.awoff <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(won[1], 0);
		pulse2(1'b1, 1'b0);
		steps(1, 0, 0);
		spmc_link_if_i2.awoff <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk(won[1], 1);
		repeat (STILL + 2000) @(posedge ref_clk);
		chk(cred[1], 1);
		// high-resolution motor: timing every twenty steps
		hi_res_motor <= 1'b1;
		for (int i = 1; i <= 20; i++) begin
			pulse2(1'b1, 1'b0);
			if (i % 10 == 0)
				chk(spmc_link_if_i2.timing, i == 20);
		end
		steps(1, 20, 0);
		chk(cred[1], 0);
		hi_res_motor <= 1'b0;
		// one-pulse mode: direction level picks the sense
		one_pulse_mode <= 1'b1;
		spmc_link_if_i2.pulse_b <= 1'b1;
		repeat (2000) @(posedge ref_clk);
		repeat (3) pulse2(1'b1, 1'b1);
		spmc_link_if_i2.pulse_b <= 1'b0;
		repeat (2000) @(posedge ref_clk);
		repeat (3) pulse2(1'b1, 1'b0);
		steps(1, 3, 3);
		one_pulse_mode <= 1'b0;
		// controller registers, unmapped and read-only places
		rd(SPMC_REG_HALF, SPMC_RESP_OKAY);
		chk(rd_d, 32'h0000_0064);
		rd(8'h10, SPMC_RESP_SLVERR);
		wr(SPMC_REG_STATUS, 32'h0000_0000, SPMC_RESP_SLVERR);
		wr(SPMC_REG_HALF, 32'h0000_0004, SPMC_RESP_OKAY);
		// moves through the controller, reversal included
		wr(SPMC_REG_MOVE, 32'h0001_0003, SPMC_RESP_OKAY);
		idle();
		steps(0, 3, 0);
		wr(SPMC_REG_MOVE, 32'h0000_0003, SPMC_RESP_OKAY);
		idle();
		steps(0, 0, 3);
		// windings off through the controller blocks motion
		wr(SPMC_REG_CTRL, 32'h0000_0002, SPMC_RESP_OKAY);
		repeat (8) @(posedge ref_clk);
		chk(won[0], 0);
		wr(SPMC_REG_MOVE, 32'h0001_0005, SPMC_RESP_OKAY);
		idle();
		steps(0, 0, 0);
		wr(SPMC_REG_CTRL, 32'h0000_0000, SPMC_RESP_OKAY);
		wr(SPMC_REG_MOVE, 32'h0001_000A, SPMC_RESP_OKAY);
		idle();
		steps(0, 10, 0);
		chk(spmc_link_if_i.timing, 1);
		// resolution select, applied when stopped with timing on
		wr(SPMC_REG_CTRL, 32'h0000_0004, SPMC_RESP_OKAY);
		n = 0;
		while (spmc_link_if_i.res_sel !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		chk(spmc_link_if_i.res_sel, 1);
		// one-pulse mode through the controller
		one_pulse_mode <= 1'b1;
		wr(SPMC_REG_CTRL, 32'h0000_0005, SPMC_RESP_OKAY);
		wr(SPMC_REG_MOVE, 32'h0001_0002, SPMC_RESP_OKAY);
		idle();
		wr(SPMC_REG_MOVE, 32'h0000_0002, SPMC_RESP_OKAY);
		idle();
		steps(0, 2, 2);
		final_report();
	end
endmodule
